// ===== design/wtw_consts.vh
// Constants of the window/timeout watchdog
`ifndef WTW_CONSTS_VH
`define WTW_CONSTS_VH

// Clock and oscillator timing
`define WTW_REF_CLK_MHZ     25
`define WTW_TICK_US         1000
`define WTW_TICK_CYCLES     (`WTW_TICK_US * `WTW_REF_CLK_MHZ)

// Period select: period in ms is base shifted left by the code
`define WTW_PERIOD_BASE_MS  16'h0008
`define WTW_PERIOD_DEFAULT  3'h4
`define WTW_PERIOD_W        3
`define WTW_TIMER_W         16

// Chip operating modes
`define WTW_CHIP_OFF        3'h0
`define WTW_CHIP_STANDBY    3'h1
`define WTW_CHIP_NORMAL     3'h2
`define WTW_CHIP_SLEEP      3'h3
`define WTW_CHIP_OVERTEMP   3'h4

// Watchdog modes
`define WTW_WD_OFF          2'h0
`define WTW_WD_WINDOW       2'h1
`define WTW_WD_TIMEOUT      2'h2

// Reset causes
`define WTW_CAUSE_NONE      3'h0
`define WTW_CAUSE_EARLY     3'h1
`define WTW_CAUSE_WIN_OVF   3'h2
`define WTW_CAUSE_TO_OVF    3'h3
`define WTW_CAUSE_DISPIN    3'h4
`define WTW_CAUSE_MODESEL   3'h5

// Interrupt status bit positions
`define WTW_INT_CYCLIC_BIT  0
`define WTW_INT_BUSWAKE_BIT 1
`define WTW_INT_W           2

`endif

// ===== design/wtw_sync.v
// Two flip-flop synchroniser for an asynchronous level
`timescale 1ns/1ps
module wtw_sync (
    // Clock and reset
    input  wire ref_clk,
    input  wire sys_rst,
    // Level in and out
    input  wire asyncIn,
    output reg  syncOut_q
);
    reg meta_q;

    // First stage feeds only the second
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            meta_q    <= 1'b0;
            syncOut_q <= 1'b0;
        end else begin
            meta_q    <= asyncIn;
            syncOut_q <= meta_q;
        end
    end
endmodule // wtw_sync

// ===== design/wtw_prescale.v
// Millisecond tick generator standing in for the on-chip oscillator
`timescale 1ns/1ps
module wtw_prescale #(
    parameter integer TICK_CYCLES = 25000
) (
    // Clock and reset
    input  wire ref_clk,
    input  wire sys_rst,
    // Restart the tick phase
    input  wire clr,
    // One-cycle tick each millisecond
    output reg  tick_q
);
    reg [31:0] cnt_q;

    // Count ref_clk cycles, pulse at the end of each tick interval
    always @(posedge ref_clk) begin
        if (sys_rst || clr) begin
            cnt_q  <= 32'h0;
            tick_q <= 1'b0;
        end else if (cnt_q == TICK_CYCLES - 1) begin
            cnt_q  <= 32'h0;
            tick_q <= 1'b1;
        end else begin
            cnt_q  <= cnt_q + 32'h1;
            tick_q <= 1'b0;
        end
    end
endmodule // wtw_prescale

// ===== design/wtw_watchdog.v
// Window / timeout / off watchdog of a system basis device
//
// What this block does
// - Three modes: window, timeout and off.
// - Programmable period, default code gives 128 ms.
// - Every trigger register write restarts the timer.
// - Window mode trigger in first half resets system.
// - Valid trigger restarts timer immediately.
// - Window mode overflow resets system immediately.
// - Timeout overflow with cyclic pending resets system.
// - Disable pin change in Normal/Standby resets.
// - Mode select change in Normal resets system.
// - Watchdog reset pulses, restores default period code.
// - Disable pin high turns watchdog fully off.
// - Standby select one offs; pending interrupt re-enables.
// - Standby select write ignored while interrupt pending.
// - No trigger by period end means overflow.
// - Window mode: pin low, Normal, select zero.
// - Writing one clears an interrupt flag.
// - Timing comes from the independent oscillator tick.
// - Timeout overflow sets cyclic flag if clear.
// - Timeout: pin low, Standby/0 or Normal/1.
// - Off in Off/Overtemp/Sleep, Standby/1, pin high.
`timescale 1ns/1ps
`include "wtw_consts.vh"
module wtw_watchdog #(
    parameter integer TICK_CYCLES = `WTW_TICK_CYCLES,
    parameter integer PERIOD_W    = `WTW_PERIOD_W,
    parameter integer TIMER_W     = `WTW_TIMER_W
) (
    // Clock and reset
    input  wire                 ref_clk,
    input  wire                 sys_rst,
    // Chip state and pin
    input  wire [2:0]           chipMode,
    input  wire                 watchdogDisablePin,
    // Trigger/status register write
    input  wire                 trigWrEn,
    input  wire [PERIOD_W-1:0]  trigWrPeriodSel,
    input  wire                 trigWrModeSel,
    // Interrupt status register write and sources
    input  wire                 intWrEn,
    input  wire [`WTW_INT_W-1:0] intWrData,
    input  wire                 busWakeEvent,
    input  wire                 otherIntPending,
    // Register contents
    output reg  [PERIOD_W-1:0]  periodSelectField_q,
    output reg                  watchdogModeSelectBit_q,
    output reg                  cyclicInterruptFlag_q,
    output reg                  busWakeupInterruptFlag_q,
    // Watchdog state
    output reg  [1:0]           wdMode_q,
    output reg  [TIMER_W-1:0]   timerMs_q,
    output reg                  intPending_q,
    // System reset request
    output reg                  sysResetReq_q,
    output reg  [2:0]           resetCause_q
);
    // Mode table while the synchronised pin is low:
    //   Normal,  select 0   -> window
    //   Normal,  select 1   -> timeout
    //   Standby, select 0   -> timeout
    //   Standby, select 1   -> off, until an interrupt is pending
    //   any other chip mode -> off
    // A high pin forces off in every chip mode.
    //
    // Timing:
    //   The pin is seen two cycles late, so its reset request follows
    //   a pin change by three cycles.
    //   The timer counts whole oscillator ticks since the last restart;
    //   the tick phase restarts with it, so every period is exact.
    //   A trigger in the tick that would overflow wins over the overflow.
    //   A trigger exactly at half the period falls in the open window.
    //
    // Faults, highest first: pin change, select change in Normal,
    // early trigger, window overflow, timeout overflow with the cyclic
    // flag already set. Only the winning cause is reported.
    // The cyclic flag survives a watchdog reset; the host must clear it.
    // Pulse shaping of the system reset is left to the reset pin logic.
    //
    // Synchronised disable pin and its previous level
    wire                disSync;
    reg                 disPrev_q;
    // Oscillator tick
    wire                msTick;
    reg                 tickClr;
    // Previous watchdog mode
    reg  [1:0]          modePrev_q;
    // Combinational results
    reg  [1:0]          curMode;
    reg  [TIMER_W-1:0]  periodMs;
    reg  [TIMER_W-1:0]  halfMs;
    reg                 intPend;
    reg                 chipActive;
    reg                 overflow;
    reg                 earlyTrig;
    reg                 pinChange;
    reg                 selChange;
    reg                 selAccept;
    reg                 selReenable;
    reg                 leaveOff;
    reg                 wdFault;
    reg  [2:0]          faultCause;
    reg                 cyclicSet;
    reg                 restart;

    // Disable pin crosses in through two flip-flops
    wtw_sync u_disSync (
        .ref_clk   (ref_clk),
        .sys_rst   (sys_rst),
        .asyncIn   (watchdogDisablePin),
        .syncOut_q (disSync)
    );

    // Period timing runs off the oscillator tick only
    wtw_prescale #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_osc (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .clr     (tickClr),
        .tick_q  (msTick)
    );

    // Mode selection from chip mode, pin and select bit
    always @* begin
        curMode = `WTW_WD_OFF;
        if (disSync) begin
            curMode = `WTW_WD_OFF;
        end else if (chipMode == `WTW_CHIP_NORMAL) begin
            if (watchdogModeSelectBit_q) begin
                curMode = `WTW_WD_TIMEOUT;
            end else begin
                curMode = `WTW_WD_WINDOW;
            end
        end else if (chipMode == `WTW_CHIP_STANDBY) begin
            if (watchdogModeSelectBit_q) begin
                curMode = `WTW_WD_OFF;
            end else begin
                curMode = `WTW_WD_TIMEOUT;
            end
        end else begin
            curMode = `WTW_WD_OFF;
        end
    end

    // Period length and window boundary in ms
    always @* begin
        periodMs = `WTW_PERIOD_BASE_MS << periodSelectField_q;
        halfMs   = periodMs >> 1;
    end

    // Event detection
    always @* begin
        intPend    = cyclicInterruptFlag_q | busWakeupInterruptFlag_q | otherIntPending;
        chipActive = (chipMode == `WTW_CHIP_NORMAL) || (chipMode == `WTW_CHIP_STANDBY);
        // Overflow when the period ends with no trigger
        overflow   = (curMode != `WTW_WD_OFF) && msTick && !trigWrEn
                     && (timerMs_q >= periodMs - 16'h0001);
        // Trigger within the closed half of a window period
        earlyTrig  = (curMode == `WTW_WD_WINDOW) && trigWrEn
                     && (timerMs_q < halfMs);
        pinChange  = chipActive && (disSync != disPrev_q);
        leaveOff   = (modePrev_q == `WTW_WD_OFF) && (curMode != `WTW_WD_OFF);
    end

    // Select bit write handling
    always @* begin
        // Select writes in Standby are dropped while an interrupt is pending
        selAccept  = trigWrEn
                     && !((chipMode == `WTW_CHIP_STANDBY) && intPend);
        selChange  = trigWrEn && (chipMode == `WTW_CHIP_NORMAL)
                     && (trigWrModeSel != watchdogModeSelectBit_q);
        // Switched off by select bit in Standby: pending interrupt turns it back on
        selReenable = (chipMode == `WTW_CHIP_STANDBY) && watchdogModeSelectBit_q
                      && intPend && !disSync;
    end

    // Fault priority and cause
    always @* begin
        wdFault    = 1'b0;
        faultCause = `WTW_CAUSE_NONE;
        cyclicSet  = 1'b0;
        if (pinChange) begin
            wdFault    = 1'b1;
            faultCause = `WTW_CAUSE_DISPIN;
        end else if (selChange) begin
            wdFault    = 1'b1;
            faultCause = `WTW_CAUSE_MODESEL;
        end else if (earlyTrig) begin
            wdFault    = 1'b1;
            faultCause = `WTW_CAUSE_EARLY;
        end else if (overflow && (curMode == `WTW_WD_WINDOW)) begin
            wdFault    = 1'b1;
            faultCause = `WTW_CAUSE_WIN_OVF;
        end else if (overflow && (curMode == `WTW_WD_TIMEOUT)) begin
            if (cyclicInterruptFlag_q) begin
                wdFault    = 1'b1;
                faultCause = `WTW_CAUSE_TO_OVF;
            end else begin
                cyclicSet = 1'b1;
            end
        end
        // Timer starts over on trigger, overflow, fault or leaving off
        restart = trigWrEn || overflow || wdFault || leaveOff;
        tickClr = restart;
    end

    // Timer in ms since the start of the period
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            timerMs_q <= {TIMER_W{1'b0}};
        end else if (restart || (curMode == `WTW_WD_OFF)) begin
            timerMs_q <= {TIMER_W{1'b0}};
        end else if (msTick) begin
            timerMs_q <= timerMs_q + {{(TIMER_W-1){1'b0}}, 1'b1};
        end
    end

    // Period select field: a watchdog reset puts back the default code
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            periodSelectField_q <= `WTW_PERIOD_DEFAULT;
        end else if (wdFault) begin
            periodSelectField_q <= `WTW_PERIOD_DEFAULT;
        end else if (trigWrEn) begin
            periodSelectField_q <= trigWrPeriodSel;
        end
    end

    // Mode select bit: re-enable by a pending interrupt beats a write
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            watchdogModeSelectBit_q <= 1'b0;
        end else if (selReenable) begin
            watchdogModeSelectBit_q <= 1'b0;
        end else if (selAccept) begin
            watchdogModeSelectBit_q <= trigWrModeSel;
        end
    end

    // Cyclic flag: write one clears, an overflow in the same cycle wins
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            cyclicInterruptFlag_q <= 1'b0;
        end else if (cyclicSet) begin
            cyclicInterruptFlag_q <= 1'b1;
        end else if (intWrEn && intWrData[`WTW_INT_CYCLIC_BIT]) begin
            cyclicInterruptFlag_q <= 1'b0;
        end
    end

    // Bus wakeup flag: write one clears, a wakeup in the same cycle wins
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            busWakeupInterruptFlag_q <= 1'b0;
        end else if (busWakeEvent) begin
            busWakeupInterruptFlag_q <= 1'b1;
        end else if (intWrEn && intWrData[`WTW_INT_BUSWAKE_BIT]) begin
            busWakeupInterruptFlag_q <= 1'b0;
        end
    end

    // Edge history of the pin and the mode, for change detection
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            disPrev_q  <= 1'b0;
            modePrev_q <= `WTW_WD_OFF;
        end else begin
            disPrev_q  <= disSync;
            modePrev_q <= curMode;
        end
    end

    // Reported mode, one cycle behind curMode, so three cycles behind the disable pin
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            wdMode_q <= `WTW_WD_OFF;
        end else begin
            wdMode_q <= curMode;
        end
    end

    // Reported pending interrupt, one cycle behind its sources
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            intPending_q <= 1'b0;
        end else begin
            intPending_q <= intPend;
        end
    end

    // One-cycle system reset request
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            sysResetReq_q <= 1'b0;
        end else begin
            sysResetReq_q <= wdFault;
        end
    end

    // Cause of the last watchdog reset, kept until the next one
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            resetCause_q <= `WTW_CAUSE_NONE;
        end else if (wdFault) begin
            resetCause_q <= faultCause;
        end
    end
endmodule // wtw_watchdog

// ===== dv/wtw_host.sv
// Host model that services the watchdog through register writes
`timescale 1ns/1ps
module wtw_host (
    // Clock
    input  wire       ref_clk,
    // Register writes
    output reg        trigWrEn,
    output reg  [2:0] trigWrPeriodSel,
    output reg        trigWrModeSel,
    output reg        intWrEn,
    output reg  [1:0] intWrData
);
    // Idle at time zero
    initial begin
        {trigWrEn, trigWrPeriodSel, trigWrModeSel, intWrEn, intWrData} = 8'h00;
    end
    // One trigger write, held across one rising edge
    task write(input logic [2:0] code, input logic sel);
        @(negedge ref_clk);
        {trigWrEn, trigWrPeriodSel, trigWrModeSel} = {1'b1, code, sel};
        @(negedge ref_clk);
        {trigWrEn, trigWrPeriodSel, trigWrModeSel} = {1'b0, ~code, ~sel};
    endtask
    // Clear flags by writing ones
    task clr(input logic [1:0] d);
        @(negedge ref_clk);
        {intWrEn, intWrData} = {1'b1, d};
        @(negedge ref_clk);
        {intWrEn, intWrData} = {1'b0, ~d};
    endtask
endmodule // wtw_host

// ===== dv/wtw_watchdog_asserts.sv
// Checker of the watchdog ports
`timescale 1ns/1ps
module wtw_chk (
    input wire        ref_clk,
    input wire        sys_rst,
    input wire [2:0]  chipMode,
    input wire        watchdogDisablePin,
    input wire        trigWrEn,
    input wire        trigWrModeSel,
    input wire [2:0]  periodSelectField_q,
    input wire        watchdogModeSelectBit_q,
    input wire        cyclicInterruptFlag_q,
    input wire [1:0]  wdMode_q,
    input wire [15:0] timerMs_q,
    input wire        sysResetReq_q
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    // Trigger in the closed half of a window period
    sequence sEarly;
        trigWrEn && wdMode_q == 2'h1 && chipMode == 3'h2 && !watchdogModeSelectBit_q
        && timerMs_q < (16'h0004 << periodSelectField_q);
    endsequence
    // Default code in place with the pulse, pulse gone one cycle later
    sequence sPulse;
        periodSelectField_q == 3'h4 ##1 !sysResetReq_q;
    endsequence
    early_trig_reset_a: assert property (sEarly |=> sysResetReq_q)
        else $error("early trigger gave no reset");
    trig_restart_a: assert property (trigWrEn |=> timerMs_q == 16'h0000)
        else $error("trigger did not restart timer");
    sel_change_a: assert property (trigWrEn && chipMode == 3'h2 &&
        trigWrModeSel != watchdogModeSelectBit_q |=> sysResetReq_q)
        else $error("select change gave no reset");
    reset_pulse_a: assert property (sysResetReq_q |-> sPulse)
        else $error("reset pulse or default period wrong");
    pin_off_a: assert property (watchdogDisablePin [*4] |-> wdMode_q == 2'h0)
        else $error("watchdog on with pin high");
    window_mode_a: assert property ((!watchdogDisablePin && chipMode == 3'h2 &&
        !watchdogModeSelectBit_q) [*4] |-> wdMode_q == 2'h1)
        else $error("window mode not selected");
    chip_off_a: assert property ((chipMode == 3'h0 || chipMode >= 3'h3) [*2]
        |-> wdMode_q == 2'h0)
        else $error("watchdog on in off chip mode");
    cyclic_set_a: assert property ($rose(cyclicInterruptFlag_q) |-> wdMode_q == 2'h2)
        else $error("cyclic flag outside timeout mode");
endmodule // wtw_chk
bind wtw_watchdog wtw_chk chk (.ref_clk, .sys_rst, .chipMode, .watchdogDisablePin, .trigWrEn,
    .trigWrModeSel, .periodSelectField_q, .watchdogModeSelectBit_q, .cyclicInterruptFlag_q,
    .wdMode_q, .timerMs_q, .sysResetReq_q);

// ===== dv/wtw_tb.sv
// Self-checking bench of the watchdog
`timescale 1ns/1ps
module tb;
    // Clock, reset and chip inputs
    reg         ref_clk = 1'b0;
    reg         sys_rst = 1'b1;
    reg  [2:0]  chipMode = 3'h0;
    reg         pin = 1'b0;
    reg         busWake = 1'b0;
    reg         othInt = 1'b0;
    // Host side and outputs
    wire        wEn, wSel, iEn, selQ, cycQ, bwQ, pendQ, rstQ;
    wire [2:0]  wCode, perQ, causeQ;
    wire [1:0]  iDat, modeQ;
    wire [15:0] tmQ;
    int         n_fail = 0;
    int         n_checks = 0;
    int         n;
    logic [2:0] code;
    always #20 ref_clk = ~ref_clk;
    wtw_host host (.ref_clk(ref_clk), .trigWrEn(wEn), .trigWrPeriodSel(wCode),
        .trigWrModeSel(wSel), .intWrEn(iEn), .intWrData(iDat));
    wtw_watchdog #(.TICK_CYCLES(4)) dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .chipMode(chipMode), .watchdogDisablePin(pin), .trigWrEn(wEn),
        .trigWrPeriodSel(wCode), .trigWrModeSel(wSel), .intWrEn(iEn), .intWrData(iDat),
        .busWakeEvent(busWake), .otherIntPending(othInt), .periodSelectField_q(perQ),
        .watchdogModeSelectBit_q(selQ), .cyclicInterruptFlag_q(cycQ),
        .busWakeupInterruptFlag_q(bwQ), .wdMode_q(modeQ), .timerMs_q(tmQ),
        .intPending_q(pendQ), .sysResetReq_q(rstQ), .resetCause_q(causeQ));
    // Verdict and end of run
    task end_of_test;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task rng(input int got, input int lo, input int hi);
        n_checks++;
        if (got < lo || got > hi) begin
            n_fail++;
            $display("mismatch at %0t got %h exp %h..%h", $time, got, lo, hi);
        end
    endtask
    // Bounded waits on the reset pulse or on the timer
    task wait_rst(input int lim);
        n = 0;
        while (rstQ !== 1'b1 && n < lim) begin
            @(negedge ref_clk);
            n++;
        end
        if (rstQ !== 1'b1) begin
            n_fail++;
            end_of_test;
        end
    endtask
    task wait_tm(input logic [15:0] t);
        n = 0;
        while ((tmQ >= t) !== 1'b1 && n < 5000) begin
            @(negedge ref_clk);
            n++;
        end
        if ((tmQ >= t) !== 1'b1) begin
            n_fail++;
            end_of_test;
        end
    endtask
    task cyc(input int k);
        repeat (k) @(negedge ref_clk);
    endtask
    initial begin
        void'($urandom(48));
        cyc(20);
        sys_rst = 1'b0;
        chk(perQ, 16'h4);
        chk(causeQ, 16'h0);
        chipMode = 3'h2;
        cyc(4);
        chk(modeQ, 16'h1);
        host.write(3'h0, 1'b0);
        chk({rstQ, causeQ}, 16'h9);
        cyc(1);
        chk(perQ, 16'h4);
        $display("window early test done");
        code = 3'h4;
        repeat (4) begin
            wait_tm(16'h0004 << code);
            code = 3'h3 + $urandom % 3;
            host.write(code, 1'b0);
            chk({rstQ, tmQ}, 16'h0);
            chk(perQ, code);
        end
        wait_rst(9000);
        rng(n, (32 << code) - 6, (32 << code) + 4);
        chk(causeQ, 16'h2);
        host.write(3'h4, 1'b1);
        chk({rstQ, causeQ}, 16'hD);
        $display("window overflow test done");
        chipMode = 3'h1;
        host.write(3'h4, 1'b0);
        cyc(2);
        chk(modeQ, 16'h2);
        wait_tm(16'h007F);
        cyc(8);
        chk({cycQ, rstQ}, 16'h2);
        wait_rst(700);
        chk({cycQ, causeQ}, 16'hB);
        host.clr(2'h1);
        chk(cycQ, 16'h0);
        othInt = 1'b1;
        cyc(2);
        chk(pendQ, 16'h1);
        host.write(3'h4, 1'b1);
        chk(selQ, 16'h0);
        othInt = 1'b0;
        cyc(2);
        host.write(3'h4, 1'b1);
        cyc(2);
        chk({selQ, modeQ}, 16'h4);
        busWake = 1'b1;
        cyc(1);
        busWake = 1'b0;
        cyc(3);
        chk({bwQ, selQ, modeQ}, 16'hA);
        host.clr(2'h2);
        chk(bwQ, 16'h0);
        $display("timeout and standby test done");
        pin = 1'b1;
        wait_rst(8);
        chk(causeQ, 16'h4);
        cyc(4);
        chk(modeQ, 16'h0);
        pin = 1'b0;
        wait_rst(8);
        chipMode = 3'h3;
        cyc(3);
        chk(modeQ, 16'h0);
        $display("disable pin test done");
        end_of_test;
    end
endmodule // tb
